// [core/clw_engine.sv]
// Purpose: command interpreter writing display lists, with fault handling
// Assumes: single 40 MHz clock, APB master on the same clock
// Notes:   decoders live outside; they report bad streams on DECODE_ERR_I
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module clw_engine
  import clw_pkg::*;
#(
  parameter int          DL_WORDS       = DL_WORDS_DEF,
  parameter logic [31:0] FONT_ROOT_ADDR = 32'h0000_1000  // plain default
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [15:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic        DECODE_ERR_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             CMD_EMPTY_EVT_O
);
  localparam int DL_AW = $clog2(DL_WORDS);

  // ****************************************
  // elaboration check
  // ****************************************
  // list window is 8 KB and the offset counter is 13 bits
  if (DL_WORDS < 2 || DL_WORDS > 2048 || (DL_WORDS & (DL_WORDS - 1)) != 0) begin : g_bad
    $error("DL_WORDS must be a power of two from 2 to 2048");
  end

  // ****************************************
  // functions
  // ****************************************
  // arguments that follow each opcode
  function automatic logic [1:0] op_args(input logic [7:0] op);
    case (op)
      OP_BG_COLOUR, OP_FG_COLOUR, OP_HL_COLOUR, OP_SCRATCH,
      OP_IMAGE_DECODE, OP_DECOMPRESS: op_args = 2'h1;
      OP_MEDIA_SETUP, OP_FONT_ASSIGN, OP_FONT_REGISTER: op_args = 2'h2;
      default: op_args = 2'h0;
    endcase
  endfunction

  // address of a built-in metrics block inside the rom array
  function automatic logic [31:0] font_block_addr(input logic [5:0] font);
    font_block_addr = FONT_ROOT_ADDR
                    + FONT_BLOCK_BYTES * {26'h0, 6'(font - ROM_FONT_FIRST)};
  endfunction

  // apb write strobe for one register
  function automatic logic reg_write(input logic wr, input logic [15:0] a,
                                     input logic [15:0] r);
    reg_write = wr && (a == r);
  endfunction

  // ****************************************
  // storage and state
  // ****************************************
  logic [31:0] cmd_mem [1024];
  logic [31:0] dl_mem  [DL_WORDS];
  logic [31:0] font_ptr_q [32];
  logic [5:0]  font_id_q  [32];
  clw_state_t  st_q;
  logic        eng_rst_q;
  logic [11:0] rd_q, wr_q, fetch_q;
  logic [12:0] offset_q;
  logic [1:0]  argc_q;
  logic [7:0]  op_q;
  logic [31:0] arg0_q;
  logic [23:0] bg_q, fg_q, hl_q;
  logic [31:0] media_base_q, media_len_q;
  logic [4:0]  scratch_q, font_sel_q;
  logic        derr_m_q, derr_q;
  logic        pready_q, pslverr_q, evt_q;
  logic [31:0] prdata_q, rd_mux;

  // ****************************************
  // apb decode
  // ****************************************
  wire setup   = PSEL_I && !PENABLE_I;
  wire wr_acc  = PSEL_I && PENABLE_I && PWRITE_I && pready_q;
  wire in_cmd  = PADDR_I[15:12] == CMD_WIN_TAG;
  wire in_dl   = (PADDR_I[15:13] == DL_WIN_TAG) && ({1'b0, PADDR_I[12:2]} < 12'(DL_WORDS));
  wire in_reg  = (PADDR_I <= REG_FONT_INFO) && (PADDR_I[1:0] == 2'h0);
  wire mapped  = in_cmd || in_dl || in_reg;
  // read pointer and list offset only take host writes while the engine is held
  wire host_rd_wr  = eng_rst_q && reg_write(wr_acc, PADDR_I, REG_CMD_READ);
  wire host_off_wr = eng_rst_q && reg_write(wr_acc, PADDR_I, REG_LIST_OFFSET);

  // ****************************************
  // engine decode
  // ****************************************
  wire        running   = !eng_rst_q;
  wire [31:0] cur_word  = cmd_mem[fetch_q[11:2]];
  wire        have_word = fetch_q != wr_q;
  wire        is_cmd    = cur_word[31:8] == CMD_PREFIX;
  wire [1:0]  nargs     = op_args(cur_word[7:0]);
  wire        consume   = running && have_word && (st_q == ST_OPCODE || st_q == ST_ARGS);
  wire        raw_now   = (st_q == ST_OPCODE) && !is_cmd;
  wire        done_now  = consume && (raw_now || (st_q == ST_OPCODE && nargs == 2'h0)
                                      || (st_q == ST_ARGS && argc_q == 2'h1));
  wire [7:0]  exe_op    = (st_q == ST_OPCODE) ? cur_word[7:0] : op_q;
  wire        dl_push   = done_now && (raw_now || exe_op == OP_FILL_COLOUR);
  wire [31:0] dl_word   = raw_now ? cur_word : {COLOUR_WORD_TAG, fg_q};
  wire        dl_full   = offset_q == 13'(DL_WORDS);
  wire        overflow  = dl_push && dl_full;
  wire        fault_now = running && st_q != ST_FAULT && (overflow || derr_q);
  wire        exe       = done_now && !fault_now;
  wire        cmd_exe   = exe && !raw_now;
  wire [11:0] fetch_nx  = fetch_q + PTR_STEP;
  wire        state_rst = eng_rst_q || (cmd_exe && exe_op == OP_COLD_START);
  wire        font_ok   = cur_word[5:0] >= ROM_FONT_FIRST && cur_word[5:0] <= ROM_FONT_LAST
                          && cur_word[31:6] == 26'h0 && arg0_q[31:5] == 27'h0;
  wire        idle      = running && st_q == ST_OPCODE && !have_word;
  wire [5:0]  sel_id    = font_id_q[font_sel_q];
  wire        sel_high  = sel_id == ROM_FONT_HIGH_A || sel_id == ROM_FONT_HIGH_B;
  wire [7:0]  sel_first = (sel_id == 6'h00 || sel_high) ? 8'h00 : GLYPH_FIRST;
  wire [7:0]  sel_last  = (sel_id == 6'h00) ? GLYPH_FULL_LAST
                        : (sel_high ? GLYPH_HIGH_LAST : GLYPH_LAST);

  // ****************************************
  // pin synchroniser for the decoder error
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      derr_m_q <= 1'b0;
      derr_q   <= 1'b0;
    end else begin
      derr_m_q <= DECODE_ERR_I;
      derr_q   <= derr_m_q;
    end
  end

  // ****************************************
  // apb slave, one wait-free access phase
  // ****************************************
  always_comb begin
    rd_mux = 32'h0;
    if (in_cmd) begin
      rd_mux = cmd_mem[PADDR_I[11:2]];
    end else if (in_dl) begin
      rd_mux = dl_mem[PADDR_I[DL_AW+1:2]];
    end else begin
      case (PADDR_I)
        REG_ENGINE_RESET: rd_mux = {31'h0, eng_rst_q};
        REG_CMD_READ:     rd_mux = {20'h0, rd_q};
        REG_CMD_WRITE:    rd_mux = {20'h0, wr_q};
        REG_LIST_OFFSET:  rd_mux = {19'h0, offset_q};
        REG_STATUS:       rd_mux = {30'h0, idle, st_q == ST_FAULT};
        REG_BG_COLOUR:    rd_mux = {8'h0, bg_q};
        REG_FG_COLOUR:    rd_mux = {8'h0, fg_q};
        REG_HL_COLOUR:    rd_mux = {8'h0, hl_q};
        REG_MEDIA_BASE:   rd_mux = media_base_q;
        REG_MEDIA_LEN:    rd_mux = media_len_q;
        REG_SCRATCH:      rd_mux = {27'h0, scratch_q};
        REG_FONT_SEL:     rd_mux = {27'h0, font_sel_q};
        REG_FONT_PTR:     rd_mux = font_ptr_q[font_sel_q];
        REG_FONT_INFO:    rd_mux = {font_ptr_q[font_sel_q][15:0] + FONT_GLYPH_OFF[15:0],
                                    sel_last, sel_first};
        default:          rd_mux = 32'h0;
      endcase
    end
  end

  // answer registered at setup, sampled at the end of the access phase
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q  <= setup ? rd_mux : 32'h0;
    end
  end

  // command window: host only
  always_ff @(posedge REF_CLK_I) begin
    if (wr_acc && in_cmd) begin
      cmd_mem[PADDR_I[11:2]] <= PWDATA_I;
    end
  end

  // list memory: the engine wins a same-cycle clash with the host
  always_ff @(posedge REF_CLK_I) begin
    if (dl_push && !dl_full) begin
      dl_mem[offset_q[DL_AW-1:0]] <= dl_word;
    end else if (wr_acc && in_dl) begin
      dl_mem[PADDR_I[DL_AW+1:2]] <= PWDATA_I;
    end
  end

  // ****************************************
  // pointers, offset and engine sequencing
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      eng_rst_q <= 1'b0;
      wr_q      <= 12'h0;
      font_sel_q <= 5'h0;
    end else begin
      if (reg_write(wr_acc, PADDR_I, REG_ENGINE_RESET)) begin
        eng_rst_q <= PWDATA_I[0];
      end
      if (reg_write(wr_acc, PADDR_I, REG_CMD_WRITE)) begin
        wr_q <= PWDATA_I[11:0];
      end
      if (reg_write(wr_acc, PADDR_I, REG_FONT_SEL)) begin
        font_sel_q <= PWDATA_I[4:0];
      end
    end
  end

  // read pointer advances only when a whole command has run; a fault loads FAULT_READ_PTR
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      rd_q <= 12'h0;
    end else if (host_rd_wr) begin
      rd_q <= PWDATA_I[11:0];
    end else if (fault_now) begin
      rd_q <= FAULT_READ_PTR;
    end else if (exe) begin
      rd_q <= fetch_nx;
    end
  end

  // fetch pointer follows the read pointer while held
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      fetch_q <= 12'h0;
    end else if (eng_rst_q) begin
      fetch_q <= rd_q;
    end else if (consume && !fault_now) begin
      fetch_q <= fetch_nx;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      offset_q <= 13'h0;
    end else if (host_off_wr) begin
      offset_q <= PWDATA_I[12:0];
    end else if (cmd_exe && exe_op == OP_BEGIN_LIST) begin
      offset_q <= 13'h0;
    end else if (dl_push && !dl_full) begin
      offset_q <= offset_q + 13'h1;
    end
  end

  // fault is left only through the engine reset control
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I || eng_rst_q) begin
      st_q   <= ST_HOLD;
      argc_q <= 2'h0;
      op_q   <= 8'h0;
      arg0_q <= 32'h0;
    end else begin
      case (st_q)
        ST_HOLD: begin
          st_q <= fault_now ? ST_FAULT : ST_OPCODE;
        end
        ST_OPCODE: begin
          if (fault_now) begin
            st_q <= ST_FAULT;
          end else if (consume && is_cmd && nargs != 2'h0) begin
            st_q   <= ST_ARGS;
            argc_q <= nargs;
            op_q   <= cur_word[7:0];
          end
        end
        ST_ARGS: begin
          if (fault_now) begin
            st_q <= ST_FAULT;
          end else if (consume) begin
            argc_q <= argc_q - 2'h1;
            arg0_q <= cur_word;
            if (argc_q == 2'h1) begin
              st_q <= ST_OPCODE;
            end
          end
        end
        ST_FAULT: begin
          st_q <= ST_FAULT;
        end
        default: begin
          st_q <= ST_HOLD;
        end
      endcase
    end
  end

  // event on emptied buffer or on fault entry
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= (exe && fetch_nx == wr_q) || fault_now;
    end
  end

  // ****************************************
  // drawing state; begin-list and swap leave it alone
  // ****************************************
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I || state_rst) begin
      bg_q         <= BG_DEFAULT;
      fg_q         <= FG_DEFAULT;
      hl_q         <= HL_DEFAULT;
      media_base_q <= 32'h0;
      media_len_q  <= 32'h0;
      scratch_q    <= SCRATCH_DEFAULT;
    end else if (cmd_exe) begin
      case (exe_op)
        OP_BG_COLOUR: bg_q <= cur_word[23:0];
        OP_FG_COLOUR: fg_q <= cur_word[23:0];
        OP_HL_COLOUR: hl_q <= cur_word[23:0];
        OP_SCRATCH:   scratch_q <= cur_word[4:0];
        OP_MEDIA_SETUP: begin
          media_base_q <= arg0_q;
          media_len_q  <= cur_word;
        end
        default: begin
        end
      endcase
    end
  end

  // one font slot per handle
  for (genvar h = 0; h < 32; h++) begin : g_font
    localparam logic [5:0] HID = 6'(h);
    wire hit = cmd_exe && arg0_q[4:0] == HID[4:0] && arg0_q[31:5] == 27'h0;
    always_ff @(posedge REF_CLK_I) begin
      if (!RESETN_I || state_rst) begin
        font_ptr_q[h] <= (HID >= ROM_FONT_FIRST) ? font_block_addr(HID) : 32'h0;
        font_id_q[h]  <= (HID >= ROM_FONT_FIRST) ? HID : 6'h0;
      end else if (hit && exe_op == OP_FONT_ASSIGN && font_ok) begin
        font_ptr_q[h] <= font_block_addr(cur_word[5:0]);
        font_id_q[h]  <= cur_word[5:0];
      end else if (hit && exe_op == OP_FONT_REGISTER) begin
        font_ptr_q[h] <= cur_word;
        font_id_q[h]  <= 6'h0;
      end
    end
  end

  assign PRDATA_O        = prdata_q;
  assign PREADY_O        = pready_q;
  assign PSLVERR_O       = pslverr_q;
  assign CMD_EMPTY_EVT_O = evt_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);

  fault_ptr_a: assert property (fault_now |=> rd_q == FAULT_READ_PTR && st_q == ST_FAULT)
    else $error("fault did not load read pointer");
  fault_hold_a: assert property (st_q == ST_FAULT && !eng_rst_q |=> st_q == ST_FAULT
                                 && rd_q == FAULT_READ_PTR && $stable(offset_q))
    else $error("fault left without engine reset");
  fault_event_a: assert property (fault_now |=> CMD_EMPTY_EVT_O)
    else $error("fault raised no command-empty event");
  offset_step_a: assert property (dl_push && !dl_full && !host_off_wr
                                  |=> offset_q == $past(offset_q) + 13'h1)
    else $error("list offset did not advance");
  begin_clear_a: assert property (cmd_exe && exe_op == OP_BEGIN_LIST && !host_off_wr
                                  |=> offset_q == 13'h0)
    else $error("begin list did not clear offset");
  raw_copy_a: assert property (dl_push && raw_now && !dl_full
                               |=> dl_mem[$past(offset_q[DL_AW-1:0])] == $past(cur_word))
    else $error("raw word not copied");
  overflow_fault_a: assert property (overflow && running && st_q != ST_FAULT
                                     |=> st_q == ST_FAULT && offset_q == 13'(DL_WORDS))
    else $error("list overflow did not fault");
  empty_event_a: assert property (exe && fetch_nx == wr_q |=> CMD_EMPTY_EVT_O
                                  ##1 rd_q == wr_q || wr_q != $past(wr_q))
    else $error("no event after last command");
  held_default_a: assert property (eng_rst_q [*2] |-> bg_q == BG_DEFAULT
                                   && media_len_q == 32'h0 && !consume)
    else $error("state not default while held");

  raw_seen_c:  cover property (dl_push && raw_now);
  begin_c:     cover property (cmd_exe && exe_op == OP_BEGIN_LIST);
  fault_c:     cover property (fault_now);
  recover_c:   cover property (st_q == ST_FAULT ##[1:200] st_q == ST_OPCODE);
endmodule
`default_nettype wire

// [core/clw_pkg.sv]
// Purpose: shared constants for the command list writer engine
// Assumes: 32-bit APB register access, byte-addressed word registers
// Notes:   command encodings are local to this block
package clw_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [15:0] REG_ENGINE_RESET = 16'h0000;
  localparam logic [15:0] REG_CMD_READ     = 16'h0004;
  localparam logic [15:0] REG_CMD_WRITE    = 16'h0008;
  localparam logic [15:0] REG_LIST_OFFSET  = 16'h000C;
  localparam logic [15:0] REG_STATUS       = 16'h0010;
  localparam logic [15:0] REG_BG_COLOUR    = 16'h0014;
  localparam logic [15:0] REG_FG_COLOUR    = 16'h0018;
  localparam logic [15:0] REG_HL_COLOUR    = 16'h001C;
  localparam logic [15:0] REG_MEDIA_BASE   = 16'h0020;
  localparam logic [15:0] REG_MEDIA_LEN    = 16'h0024;
  localparam logic [15:0] REG_SCRATCH      = 16'h0028;
  localparam logic [15:0] REG_FONT_SEL     = 16'h002C;
  localparam logic [15:0] REG_FONT_PTR     = 16'h0030;
  localparam logic [15:0] REG_FONT_INFO    = 16'h0034;
  localparam logic [3:0]  CMD_WIN_TAG      = 4'h1;   // 0x1000..0x1FFF
  localparam logic [2:0]  DL_WIN_TAG       = 3'h2;   // 0x4000..0x5FFF
  // ****************************************
  // engine constants
  // ****************************************
  localparam logic [11:0] FAULT_READ_PTR   = 12'hFFF;
  localparam logic [11:0] PTR_STEP         = 12'h004;
  localparam int          DL_WORDS_DEF     = 2048;
  localparam logic [23:0] BG_DEFAULT       = 24'h002040;
  localparam logic [23:0] FG_DEFAULT       = 24'h003870;
  localparam logic [23:0] HL_DEFAULT       = 24'hFFFFFF;
  localparam logic [4:0]  SCRATCH_DEFAULT  = 5'h0F;
  localparam logic [31:0] FONT_BLOCK_BYTES = 32'h0000_0094; // 148
  localparam logic [31:0] FONT_GLYPH_OFF   = 32'h0000_0090; // 144
  localparam logic [5:0]  ROM_FONT_FIRST   = 6'h10;  // 16
  localparam logic [5:0]  ROM_FONT_LAST    = 6'h22;  // 34
  localparam logic [5:0]  ROM_FONT_HIGH_A  = 6'h11;  // 17
  localparam logic [5:0]  ROM_FONT_HIGH_B  = 6'h13;  // 19
  localparam logic [7:0]  GLYPH_FIRST      = 8'h20;
  localparam logic [7:0]  GLYPH_LAST       = 8'h7E;
  localparam logic [7:0]  GLYPH_HIGH_LAST  = 8'h7F;
  localparam logic [7:0]  GLYPH_FULL_LAST  = 8'hFF;
  // ****************************************
  // command encodings: 0xFFFFFF in the top bits, opcode below
  // ****************************************
  localparam logic [23:0] CMD_PREFIX       = 24'hFFFFFF;
  localparam logic [7:0]  OP_BEGIN_LIST    = 8'h00;
  localparam logic [7:0]  OP_SWAP          = 8'h01;
  localparam logic [7:0]  OP_COLD_START    = 8'h02;
  localparam logic [7:0]  OP_BG_COLOUR     = 8'h03;
  localparam logic [7:0]  OP_FG_COLOUR     = 8'h04;
  localparam logic [7:0]  OP_HL_COLOUR     = 8'h05;
  localparam logic [7:0]  OP_MEDIA_SETUP   = 8'h06;
  localparam logic [7:0]  OP_FONT_ASSIGN   = 8'h07;
  localparam logic [7:0]  OP_FONT_REGISTER = 8'h08;
  localparam logic [7:0]  OP_SCRATCH       = 8'h09;
  localparam logic [7:0]  OP_IMAGE_DECODE  = 8'h0A;
  localparam logic [7:0]  OP_DECOMPRESS    = 8'h0B;
  localparam logic [7:0]  OP_FILL_COLOUR   = 8'h0C;
  localparam logic [7:0]  COLOUR_WORD_TAG  = 8'h04;
  typedef enum logic [1:0] {
    ST_HOLD   = 2'b00,
    ST_OPCODE = 2'b01,
    ST_ARGS   = 2'b10,
    ST_FAULT  = 2'b11
  } clw_state_t;
endpackage

// [tb/clw_host.sv]
// Purpose: APB host model for the list writer engine
// Assumes: one clock shared with the engine
// Notes:   write data is inverted on release so stale values never match
`timescale 1ns/1ps
`default_nettype none
module clw_host (
  input  wire logic        clk_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [15:0] paddr_o,
  output logic      [31:0] pwdata_o
);
  // ****************************************
  // one transfer: setup, then access until ready
  // ****************************************
  initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    // no wait count assumed; only the bench watchdog ends a hang
    do @(posedge clk_i); while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o  <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench for the command list writer engine
// Assumes: list depth cut to 16 words so overflow comes quickly
// Notes:   expected values are written out, never read back from the engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clw_pkg::*;
  logic        clk, rst_n, psel, pen, pwr, rdy, slv, evt, derr;
  logic [15:0] addr;
  logic [31:0] wdat, rdat;
  int          n_errors = 0, num_checks = 0, evts = 0, wp = 0;
  // ****************************************
  // clock, engine, host and event counter
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  clw_engine #(.DL_WORDS(16), .FONT_ROOT_ADDR(32'h0000_1000)) dut (.REF_CLK_I(clk),
    .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(addr),
    .PWDATA_I(wdat), .DECODE_ERR_I(derr), .PRDATA_O(rdat), .PREADY_O(rdy),
    .PSLVERR_O(slv), .CMD_EMPTY_EVT_O(evt));
  clw_host host (.clk_i(clk), .prdata_i(rdat), .pready_i(rdy), .pslverr_i(slv),
    .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(addr), .pwdata_o(wdat));
  always @(posedge clk) if (evt === 1'b1) evts++;
  function automatic logic [31:0] cw(input logic [7:0] op);
    return {CMD_PREFIX, op};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b1, a, d, r, e);
  endtask
  // mask keeps only the fields under test
  task automatic rc(input logic [15:0] a, input logic [31:0] x,
                    input logic [31:0] m = '1, input logic xe = 1'b0);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b0, a, 32'h0, r, e);
    check(r & m, x);
    check({31'h0, e}, {31'h0, xe});
  endtask
  // queue words, publish the write pointer, poll read pointer until caught up
  task automatic run(input logic [31:0] q[$], input logic [31:0] fin);
    logic [31:0] r;
    logic        e;
    foreach (q[i]) begin
      wr(16'h1000 + wp[15:0], q[i]);
      wp = (wp + 4) % 4096;
    end
    wr(REG_CMD_WRITE, 32'(wp));
    for (int i = 0; i < 100 && r !== fin; i++) host.xfer(1'b0, REG_CMD_READ, 32'h0, r, e);
    check(r, fin);
  endtask
  task automatic t_stream;
    rc(REG_BG_COLOUR, 32'h0000_2040);
    rc(REG_FG_COLOUR, 32'h0000_3870);
    rc(REG_HL_COLOUR, 32'h00FF_FFFF);
    rc(REG_MEDIA_LEN, 32'h0);
    run('{cw(OP_BEGIN_LIST), 32'h1234_5678, cw(OP_FILL_COLOUR), cw(OP_BG_COLOUR),
          32'h00AB_CDEF}, 32'h14);
    check(32'(evts), 32'h1);
    rc(16'h4000, 32'h1234_5678);
    rc(16'h4004, 32'h0400_3870);
    rc(REG_LIST_OFFSET, 32'h2);
    run('{cw(OP_BEGIN_LIST), cw(OP_SWAP), cw(OP_MEDIA_SETUP), 32'h400, 32'h100}, 32'h28);
    rc(REG_LIST_OFFSET, 32'h0);
    rc(REG_BG_COLOUR, 32'h00AB_CDEF);
    rc(REG_MEDIA_BASE, 32'h400);
    rc(REG_MEDIA_LEN, 32'h100);
    run('{cw(OP_COLD_START)}, 32'h2C);
    rc(REG_BG_COLOUR, 32'h0000_2040);
  endtask
  task automatic t_fault;
    logic [31:0] q[$];
    q = '{cw(OP_BEGIN_LIST)};
    for (int i = 0; i < 17; i++) q.push_back(32'h100 + 32'(i));
    run(q, 32'h0000_0FFF);
    check(32'(evts), 32'h4);
    rc(REG_STATUS, 32'h1, 32'h1);
    wr(REG_CMD_READ, 32'h0);
    run('{32'h5555_0000}, 32'h0000_0FFF);
    rc(REG_LIST_OFFSET, 32'h10);
  endtask
  task automatic t_recover;
    wr(REG_ENGINE_RESET, 32'h1);
    rc(REG_ENGINE_RESET, 32'h1);
    wr(REG_CMD_READ, 32'h0);
    wr(REG_CMD_WRITE, 32'h0);
    wr(REG_LIST_OFFSET, 32'h0);
    rc(REG_CMD_READ, 32'h0);
    wr(REG_ENGINE_RESET, 32'h0);
    wp = 0;
    run('{32'h2222_0001}, 32'h4);
    rc(16'h4000, 32'h2222_0001);
    rc(REG_STATUS, 32'h0, 32'h1);
  endtask
  task automatic t_fonts;
    rc(16'h0100, 32'h0, '1, 1'b1);
    wr(REG_FONT_SEL, 32'd18);
    rc(REG_FONT_PTR, 32'h0000_1128);
    rc(REG_FONT_INFO, 32'h11B8_7E20);
    wr(REG_FONT_SEL, 32'd17);
    rc(REG_FONT_INFO, 32'h0000_7F00, 32'h0000_FFFF);
    run('{cw(OP_FONT_ASSIGN), 32'd16, 32'd34}, 32'h10);
    wr(REG_FONT_SEL, 32'd16);
    rc(REG_FONT_PTR, 32'h0000_1A68);
    run('{cw(OP_FONT_REGISTER), 32'd3, 32'h0000_2000, cw(OP_FG_COLOUR), 32'h0011_2233,
          cw(OP_HL_COLOUR), 32'h0044_5566, cw(OP_SCRATCH), 32'h0000_0007}, 32'h34);
    wr(REG_FONT_SEL, 32'd3);
    rc(REG_FONT_PTR, 32'h0000_2000);
    rc(REG_FONT_INFO, 32'h2090_FF00);
    rc(REG_FG_COLOUR, 32'h0011_2233);
    rc(REG_HL_COLOUR, 32'h0044_5566);
    rc(REG_SCRATCH, 32'h0000_0007);
  endtask
  // decoder error pin faults an idle engine; recovery must work a second time
  task automatic t_decode;
    int e0;
    run('{cw(OP_IMAGE_DECODE), 32'h0, cw(OP_DECOMPRESS), 32'h0}, 32'h44);
    rc(REG_STATUS, 32'h2, 32'h3);
    e0 = evts;
    @(posedge clk) derr <= 1'b1;
    repeat (4) @(posedge clk);
    derr <= 1'b0;
    rc(REG_CMD_READ, 32'h0000_0FFF);
    check(32'(evts - e0), 32'h1);
    rc(REG_STATUS, 32'h1, 32'h1);
    t_recover;
  endtask
  task automatic complete_run;
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    derr  = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_stream;
    t_fault;
    t_recover;
    t_fonts;
    t_decode;
    complete_run;
  end
  // watchdog: whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
